// ### logic/wwd_pkg.sv
package wwd_pkg;

    // Byte addresses of the register words
    localparam logic [15:0] ADDR_POWER_ENABLE = 16'h0800;
    localparam logic [15:0] ADDR_DEBUG_CONTROL = 16'h1018;
    localparam logic [15:0] ADDR_STATIC_CONFIG = 16'h1100;
    localparam logic [15:0] ADDR_DYNAMIC_CONFIG = 16'h1104;
    localparam logic [15:0] ADDR_COUNTER_RESTART = 16'h1108;
    localparam logic [15:0] ADDR_STATUS = 16'h110C;
    localparam logic [15:0] ADDR_LOW_POWER_CTRL = 16'h1110;

    // Keys
    localparam logic [7:0] KEY_POWER_ENABLE = 8'h26;
    localparam logic [7:0] KEY_STATIC = 8'hC9;
    localparam logic [7:0] KEY_DYNAMIC = 8'hBE;
    localparam logic [31:0] RESTART_VALUE = 32'h0000_00A7;

    // Static config field positions
    localparam int TICK_DIV_LSB = 0;
    localparam int PERIOD_SEL_LSB = 4;
    localparam int WIN_A_LSB = 8;
    localparam int WIN_B_LSB = 12;
    localparam int MODE_BIT = 16;
    localparam int STOP_LP_BIT = 17;
    localparam int KEY_LSB = 24;
    // Dynamic config, status, debug, power and low-power bits
    localparam int WIN_CHOICE_BIT = 0;
    localparam int RUN_BIT = 0;
    localparam int FREE_BIT = 0;
    localparam int POWER_BIT = 0;
    localparam int LOW_POWER_BIT = 0;

    // Reset values
    localparam logic [2:0] TICK_DIV_RESET = 3'h3;
    localparam logic [2:0] PERIOD_SEL_RESET = 3'h0;
    localparam logic [2:0] WINDOW_RESET = 3'h0;
    localparam logic [24:0] COUNT_RESET = 25'h000_0000;
    localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

    // Low-frequency clock time figure and the restart settle delay
    localparam int LF_PERIOD_NS = 30518;
    localparam int LF_SYNC_DELAY_NS = 30518;
    localparam int CLK_PERIOD_NS = 25;
    localparam int SYNC_DELAY_CYCLES = LF_SYNC_DELAY_NS / CLK_PERIOD_NS;

    typedef struct packed {
        logic stop_lp;
        logic mode;
        logic [2:0] win_b;
        logic [2:0] win_a;
        logic [2:0] period_sel;
        logic [2:0] tick_div;
    } wwd_static_type;

    typedef enum logic {
        WWD_MODE_WATCHDOG,
        WWD_MODE_INTERVAL
    } wwd_mode_type;

endpackage : wwd_pkg

// ### logic/wwd_window_watchdog.sv
`timescale 1ns/1ps
// Functional notes
// [RULE1] Software powers the block on through power_enable_reg before configuring it.
// [RULE2] Config accesses are 32-bit; writes carry key C9 or BE in top byte.
// [RULE3] Bad key or narrow write to config raises a violation; enabled interval mode gives an interrupt instead for dynamic config.
// [RULE4] Key byte of config registers always reads zero.
// [RULE5] Reset leaves watchdog disabled, counter cleared and stopped.
// [RULE6] First keyed static write loads all static fields and starts counting.
// [RULE7] Static write after enabling raises a violation.
// [RULE8] Status running flag is set while counter is active.
// [RULE9] Mode bit clear selects watchdog, set selects interval timer.
// [RULE10] Software restarts counter in open window with value A7.
// [RULE11] Reset or accepted restart counts again from zero.
// [RULE12] Violation on expiry, closed-window restart, or wrong restart value.
// [RULE13] Interval mode pulses interrupt at each period expiry, no restart needed.
// [RULE14] Tick is low-frequency clock divided by divider field plus one.
// [RULE15] Counter is 25 bits; period is divider times period count.
// [RULE16] Period select codes give 2^25,21,18,15,12,10,8,6 ticks.
// [RULE17] Start or restart may wait one low-frequency cycle before counting.
// [RULE18] Two closed windows held; window choice selects the active one.
// [RULE19] Window codes give closed share 0 to 87.5 percent of period.
// [RULE20] Software keeps window choice stable four slow cycles after restart.
// [RULE21] Stop bit set freezes counter in low power; clear keeps counting.
// [RULE22] Debug halt stops counter unless run-through bit is set.
// [RULE23] Interval mode also interrupts on a wrong config key.
// [RULE24] Violation goes to the system controller as a signal.
// [RULE25] Violation is a single main-clock pulse.
module wwd_window_watchdog (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [15:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic low_freq_clock_i,
    input wire logic debug_halt_i,
    output logic violation_o,
    output logic interval_irq_o
);
    import wwd_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Last count value of a select code (period count minus one), in ticks
    function automatic logic [24:0] period_last(input logic [2:0] sel);
        logic [25:0] n;
        n = 26'h000_0000;
        unique case (sel)
            3'h0: n = 26'h200_0000;
            3'h1: n = 26'h020_0000;
            3'h2: n = 26'h004_0000;
            3'h3: n = 26'h000_8000;
            3'h4: n = 26'h000_1000;
            3'h5: n = 26'h000_0400;
            3'h6: n = 26'h000_0100;
            3'h7: n = 26'h000_0040;
        endcase
        return 25'(n - 26'h000_0001); // [RULE16]
    endfunction : period_last

    // Closed-window end in ticks, share of the period in sixteenths
    function automatic logic [24:0] closed_end(input logic [2:0] sel, input logic [2:0] win);
        logic [29:0] full;
        logic [4:0] sixteenths;
        full = 30'(period_last(sel)) + 30'h0000_0001;
        sixteenths = 5'h00;
        unique case (win)
            3'h0: sixteenths = 5'd0;
            3'h1: sixteenths = 5'd2;
            3'h2: sixteenths = 5'd3;
            3'h3: sixteenths = 5'd4;
            3'h4: sixteenths = 5'd8;
            3'h5: sixteenths = 5'd12;
            3'h6: sixteenths = 5'd13;
            3'h7: sixteenths = 5'd14;
        endcase
        return 25'((full >> 4) * 30'(sixteenths)); // [RULE19]
    endfunction : closed_end

    ////////////////////////////////////////////////////////////////////////
    // Bus decode; every access answers in one cycle
    logic access;
    logic wr;
    logic full_word;
    logic key_ok_static;
    logic key_ok_dynamic;
    assign access = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr = access && wb_we_i;
    assign full_word = (wb_sel_i == 4'hF); // [RULE2]
    assign key_ok_static = wb_dat_i[31:KEY_LSB] == KEY_STATIC;
    assign key_ok_dynamic = wb_dat_i[31:KEY_LSB] == KEY_DYNAMIC;

    logic power_q;
    logic free_q;
    logic low_power_q;
    logic enabled_q;
    logic win_choice_q;
    wwd_static_type cfg_q;
    logic [24:0] count_q;
    logic settle_q;

    logic wr_static;
    logic wr_dynamic;
    logic wr_restart;
    assign wr_static = wr && power_q && wb_adr_i == ADDR_STATIC_CONFIG;
    assign wr_dynamic = wr && power_q && wb_adr_i == ADDR_DYNAMIC_CONFIG;
    assign wr_restart = wr && power_q && wb_adr_i == ADDR_COUNTER_RESTART;

    logic bad_key;
    logic static_load;
    assign bad_key = (wr_static && !(full_word && key_ok_static))
        || (wr_dynamic && !(full_word && key_ok_dynamic)); // [RULE3]
    assign static_load = wr_static && full_word && key_ok_static && !enabled_q; // [RULE6]

    ////////////////////////////////////////////////////////////////////////
    // Low-frequency tick: two-flop sync then edge detect
    logic lf_meta_q;
    logic lf_sync_q;
    logic lf_prev_q;
    logic lf_edge;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lf_meta_q <= 1'b0;
            lf_sync_q <= 1'b0;
            lf_prev_q <= 1'b0;
        end else begin
            lf_meta_q <= low_freq_clock_i;
            lf_sync_q <= lf_meta_q;
            lf_prev_q <= lf_sync_q;
        end
    end
    assign lf_edge = lf_sync_q && !lf_prev_q; // [RULE14]

    logic [2:0] div_q;
    logic tick;
    logic hold;
    // Freezing holds the divider too, so a resume keeps phase
    assign hold = (low_power_q && cfg_q.stop_lp) || (debug_halt_i && !free_q); // [RULE21] [RULE22]
    assign tick = lf_edge && !hold && div_q == cfg_q.tick_div; // [RULE14]

    ////////////////////////////////////////////////////////////////////////
    // Restart handling; settle waits for the next slow edge
    logic restart_ok;
    logic restart_bad;
    logic closed_now;
    logic [24:0] win_end;
    assign win_end = closed_end(cfg_q.period_sel,
        win_choice_q ? cfg_q.win_b : cfg_q.win_a); // [RULE18]
    assign closed_now = !settle_q && count_q < win_end;
    assign restart_ok = wr_restart && enabled_q && full_word
        && wb_dat_i == RESTART_VALUE && !closed_now && cfg_q.mode == WWD_MODE_WATCHDOG;
    assign restart_bad = wr_restart && enabled_q && cfg_q.mode == WWD_MODE_WATCHDOG
        && !restart_ok; // [RULE12]

    logic expire;
    assign expire = enabled_q && !settle_q && tick && count_q == period_last(cfg_q.period_sel);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_q <= 3'h0;
            count_q <= COUNT_RESET; // [RULE5]
            settle_q <= 1'b0;
        end else if (static_load || restart_ok) begin
            div_q <= 3'h0;
            count_q <= COUNT_RESET; // [RULE11]
            settle_q <= 1'b1; // [RULE17]
        end else if (settle_q) begin
            if (lf_edge) begin
                settle_q <= 1'b0;
            end
        end else if (enabled_q && lf_edge && !hold) begin
            div_q <= tick ? 3'h0 : div_q + 3'h1;
            if (tick) begin
                // Interval mode wraps and keeps running
                count_q <= expire ? COUNT_RESET : count_q + 25'h000_0001; // [RULE13] [RULE15]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            enabled_q <= 1'b0; // [RULE5]
            cfg_q <= '{stop_lp: 1'b0, mode: WWD_MODE_WATCHDOG, win_b: WINDOW_RESET,
                       win_a: WINDOW_RESET, period_sel: PERIOD_SEL_RESET,
                       tick_div: TICK_DIV_RESET}; // [RULE9]
        end else if (static_load) begin
            enabled_q <= 1'b1;
            cfg_q.tick_div <= wb_dat_i[TICK_DIV_LSB +: 3];
            cfg_q.period_sel <= wb_dat_i[PERIOD_SEL_LSB +: 3];
            cfg_q.win_a <= wb_dat_i[WIN_A_LSB +: 3];
            cfg_q.win_b <= wb_dat_i[WIN_B_LSB +: 3];
            cfg_q.mode <= wb_dat_i[MODE_BIT]; // [RULE9]
            cfg_q.stop_lp <= wb_dat_i[STOP_LP_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            win_choice_q <= 1'b0;
        end else if (wr_dynamic && full_word && key_ok_dynamic) begin
            win_choice_q <= wb_dat_i[WIN_CHOICE_BIT]; // [RULE18]
        end
    end

    // Power, debug and low-power controls; power needs its own key
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            power_q <= 1'b0;
            free_q <= 1'b0;
            low_power_q <= 1'b0;
        end else if (wr && full_word) begin
            if (wb_adr_i == ADDR_POWER_ENABLE && wb_dat_i[31:KEY_LSB] == KEY_POWER_ENABLE) begin
                power_q <= wb_dat_i[POWER_BIT]; // [RULE1]
            end
            if (wb_adr_i == ADDR_DEBUG_CONTROL) begin
                free_q <= wb_dat_i[FREE_BIT]; // [RULE22]
            end
            if (wb_adr_i == ADDR_LOW_POWER_CTRL) begin
                low_power_q <= wb_dat_i[LOW_POWER_BIT]; // [RULE21]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Violation and interrupt pulses, one cycle each
    logic viol_cause;
    logic irq_cause;
    logic static_relock;
    assign static_relock = wr_static && enabled_q; // [RULE7]
    assign viol_cause = (static_relock || bad_key || restart_bad
        || (expire && cfg_q.mode == WWD_MODE_WATCHDOG))
        && !(cfg_q.mode == WWD_MODE_INTERVAL && enabled_q
        && bad_key && !static_relock); // [RULE12]
    assign irq_cause = cfg_q.mode == WWD_MODE_INTERVAL && enabled_q
        && (expire || bad_key); // [RULE13] [RULE23]

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            violation_o <= 1'b0;
            interval_irq_o <= 1'b0;
        end else begin
            violation_o <= viol_cause; // [RULE24] [RULE25]
            interval_irq_o <= irq_cause;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data and ack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= UNMAPPED_READ;
        end else begin
            wb_ack_o <= access;
            wb_dat_o <= UNMAPPED_READ;
            if (access && !wb_we_i) begin
                unique case (wb_adr_i)
                    ADDR_POWER_ENABLE: wb_dat_o[POWER_BIT] <= power_q;
                    ADDR_DEBUG_CONTROL: wb_dat_o[FREE_BIT] <= free_q;
                    ADDR_LOW_POWER_CTRL: wb_dat_o[LOW_POWER_BIT] <= low_power_q;
                    // Key byte stays zero
                    ADDR_STATIC_CONFIG: begin
                        wb_dat_o[TICK_DIV_LSB +: 3] <= cfg_q.tick_div; // [RULE4]
                        wb_dat_o[PERIOD_SEL_LSB +: 3] <= cfg_q.period_sel;
                        wb_dat_o[WIN_A_LSB +: 3] <= cfg_q.win_a;
                        wb_dat_o[WIN_B_LSB +: 3] <= cfg_q.win_b;
                        wb_dat_o[MODE_BIT] <= cfg_q.mode;
                        wb_dat_o[STOP_LP_BIT] <= cfg_q.stop_lp;
                    end
                    ADDR_DYNAMIC_CONFIG: wb_dat_o[WIN_CHOICE_BIT] <= win_choice_q; // [RULE4]
                    ADDR_STATUS: wb_dat_o[RUN_BIT] <= enabled_q; // [RULE8]
                    default: wb_dat_o <= UNMAPPED_READ;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    property p_bad_key_violation;
        @(posedge clk_i) disable iff (rst_i)
        (bad_key && !enabled_q) |=> violation_o;
    endproperty
    a_bad_key_violation: assert property (p_bad_key_violation) // [RULE3]
        else $error("bad key no violation");

    property p_relock;
        @(posedge clk_i) disable iff (rst_i)
        (wr_static && enabled_q) |=> violation_o;
    endproperty
    a_relock: assert property (p_relock) else $error("locked write no violation"); // [RULE7]

    // No reset guard: the violation resets the block one cycle later
    property p_pulse;
        @(posedge clk_i)
        violation_o |=> !violation_o;
    endproperty
    a_pulse: assert property (p_pulse) else $error("violation not pulsed"); // [RULE25]

    sequence s_load;
        static_load;
    endsequence
    property p_start;
        @(posedge clk_i) disable iff (rst_i)
        s_load |=> enabled_q && count_q == 25'h000_0000 && settle_q;
    endproperty
    a_start: assert property (p_start) else $error("start did not clear counter"); // [RULE6]

    property p_restart_zero;
        @(posedge clk_i) disable iff (rst_i)
        restart_ok |=> count_q == 25'h000_0000;
    endproperty
    a_restart_zero: assert property (p_restart_zero) else $error("restart not zero"); // [RULE11]

    property p_hold;
        @(posedge clk_i) disable iff (rst_i)
        (hold && !settle_q && !static_load && !restart_ok) |=> $stable(count_q);
    endproperty
    a_hold: assert property (p_hold) else $error("counter moved while held"); // [RULE22]

    property p_closed;
        @(posedge clk_i) disable iff (rst_i)
        (wr_restart && enabled_q && closed_now && cfg_q.mode == WWD_MODE_WATCHDOG) |=> violation_o;
    endproperty
    a_closed: assert property (p_closed) else $error("closed restart no violation"); // [RULE12]

    property p_interval;
        @(posedge clk_i) disable iff (rst_i)
        (expire && cfg_q.mode == WWD_MODE_INTERVAL) |=> interval_irq_o && !violation_o;
    endproperty
    a_interval: assert property (p_interval) else $error("interval expiry wrong"); // [RULE13]

    property p_wrong_restart;
        @(posedge clk_i) disable iff (rst_i)
        (wr_restart && enabled_q && cfg_q.mode == WWD_MODE_WATCHDOG
            && wb_dat_i != RESTART_VALUE) |=> violation_o;
    endproperty
    a_wrong_restart: assert property (p_wrong_restart) // [RULE12]
        else $error("bad restart no violation");

    property p_interval_key;
        @(posedge clk_i) disable iff (rst_i)
        (bad_key && enabled_q && cfg_q.mode == WWD_MODE_INTERVAL && !static_relock)
            |=> interval_irq_o && !violation_o;
    endproperty
    a_interval_key: assert property (p_interval_key) // [RULE23]
        else $error("interval key no interrupt");

    property p_key_read;
        @(posedge clk_i) disable iff (rst_i)
        (access && !wb_we_i && (wb_adr_i == ADDR_STATIC_CONFIG
            || wb_adr_i == ADDR_DYNAMIC_CONFIG)) |=> wb_dat_o[31:KEY_LSB] == 8'h00;
    endproperty
    a_key_read: assert property (p_key_read) else $error("key byte not zero"); // [RULE4]

endmodule : wwd_window_watchdog

// ### verification/wwd_partner.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Low-frequency oscillator and system controller beside the watchdog
module wwd_partner #(
    parameter int LF_HALF = 8
) (
    input wire logic clk_i,
    input wire logic violation_i,
    output logic lf_clk_o,
    output logic sys_rst_o,
    output int viol_count_o
);
    int div_q = 0;
    int cnt_q = 0;
    logic lf_q = 1'b0;
    logic [1:0] rst_q = 2'b00;
    ////////////////////////////////////////////////////////////////////////////
    // Oscillator runs free; it is a clock source, not a framed link
    always_ff @(posedge clk_i) begin
        div_q <= (div_q == LF_HALF - 1) ? 0 : div_q + 1;
        if (div_q == LF_HALF - 1) begin
            lf_q <= ~lf_q;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // High cycles are counted, so a stretched pulse shows as extra events
    always_ff @(posedge clk_i) begin
        rst_q <= {rst_q[0], violation_i === 1'b1};
        if (violation_i === 1'b1) begin
            cnt_q <= cnt_q + 1;
        end
    end
    assign sys_rst_o = |rst_q;
    assign lf_clk_o = lf_q;
    assign viol_count_o = cnt_q;
endmodule : wwd_partner

// ### verification/wwd_window_watchdog_tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin \
    cmp_count++; \
    if ((g) !== (e)) begin \
        num_errors++; \
        $display("FAIL %s expected %h seen %h", n, e, g); \
    end \
end
module wwd_window_watchdog_tb_top;
    import wwd_pkg::*;
    localparam int LF = 16;
    localparam int WA[5] = '{4, 4, 4, 0, 0};
    localparam int WB[5] = '{0, 0, 0, 7, 7};
    localparam int CH[5] = '{0, 0, 1, 1, 0};
    localparam int TK[5] = '{24, 40, 2, 40, 2};
    localparam int EV[5] = '{1, 0, 0, 1, 0};
    localparam int PR[3] = '{7, 7, 6};
    localparam int DV[3] = '{0, 2, 0};
    localparam int TT[3] = '{64, 192, 256};
    logic clk_i = 1'b0;
    logic bench_rst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [15:0] adr = 16'h0000;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0000_0000;
    logic debug_halt = 1'b0;
    logic [31:0] rdat;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, violation_o, interval_irq_o, lf_clk, sys_rst;
    int viol_seen;
    int exp_viol = 0;
    int num_errors = 0;
    int cmp_count = 0;
    int cyc_n = 0;
    int irq_n = 0;
    int t_irq = 0;
    int gap = 0;
    wwd_window_watchdog DUT (.clk_i(clk_i), .rst_i(bench_rst | sys_rst), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .low_freq_clock_i(lf_clk),
        .debug_halt_i(debug_halt), .violation_o(violation_o), .interval_irq_o(interval_irq_o));
    wwd_partner #(.LF_HALF(LF / 2)) sysc (.clk_i(clk_i), .violation_i(violation_o),
        .lf_clk_o(lf_clk), .sys_rst_o(sys_rst), .viol_count_o(viol_seen));
    initial begin
        forever #12.5 clk_i = ~clk_i;
    end
    ////////////////////////////////////////////////////////////////////////////
    // Interrupt spacing and hang guard
    always @(posedge clk_i) begin
        cyc_n <= cyc_n + 1;
        if (interval_irq_o === 1'b1) begin
            irq_n <= irq_n + 1;
            gap <= cyc_n - t_irq;
            t_irq <= cyc_n;
        end
        if (cyc_n == 60000) begin
            num_errors++;
            results();
        end
    end
    task results;
        $display("errors %0d comparisons %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : results
    ////////////////////////////////////////////////////////////////////////////
    task wait_c(input int n);
        repeat (n) @(posedge clk_i);
    endtask : wait_c
    task wb(input logic w, input logic [15:0] a, input logic [3:0] s, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        dat <= d;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        rdat = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    function automatic logic [31:0] cfgw(input int dv, period_select, wa, wbb, md, sp);
        return {KEY_STATIC, 6'h00, 1'(sp), 1'(md), 1'b0, 3'(wbb), 1'b0, 3'(wa), 1'b0,
            3'(period_select), 1'b0, 3'(dv)};
    endfunction : cfgw
    // Violations reset the chip, so every setup starts from reset
    task start(input int dv, period_select, wa, wbb, md, sp);
        bench_rst <= 1'b1;
        wait_c(3);
        bench_rst <= 1'b0;
        wb(1'b1, ADDR_POWER_ENABLE, 4'hF, {KEY_POWER_ENABLE, 24'h00_0001});
        wb(1'b1, ADDR_STATIC_CONFIG, 4'hF, cfgw(dv, period_select, wa, wbb, md, sp));
    endtask : start
    task chv(input int inc);
        wait_c(8);
        exp_viol += inc;
    endtask : chv
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] r;
        int n0;
        void'($urandom(32'h4189));
        wait_c(3);
        bench_rst <= 1'b0;
        wb(1'b0, ADDR_STATUS, 4'hF, 32'h0000_0000);
        `CHK("status", 32'h0000_0000, rdat)
        wb(1'b0, ADDR_STATIC_CONFIG, 4'hF, 32'h0000_0000);
        `CHK("static", 32'h0000_0003, rdat)
        wb(1'b0, 16'h1200, 4'hF, 32'h0000_0000);
        `CHK("unmapped", UNMAPPED_READ, rdat)
        wb(1'b1, ADDR_POWER_ENABLE, 4'hF, {KEY_POWER_ENABLE, 24'h00_0001});
        r = $urandom;
        if (r[7:0] == KEY_DYNAMIC) r[7:0] = 8'h00;
        wb(1'b1, ADDR_DYNAMIC_CONFIG, 4'hF, {r[7:0], 24'h00_0001});
        chv(1);
        `CHK("violations", exp_viol, viol_seen)
        wait_c(2);
        wb(1'b1, ADDR_POWER_ENABLE, 4'hF, {KEY_POWER_ENABLE, 24'h00_0001});
        wb(1'b1, ADDR_STATIC_CONFIG, 4'h3, cfgw(0, 7, 4, 0, 0, 0));
        chv(1);
        `CHK("violations", exp_viol, viol_seen)
        start(0, 7, 4, 0, 0, 0);
        wb(1'b0, ADDR_STATUS, 4'hF, 32'h0000_0000);
        `CHK("status", 32'h0000_0001, rdat)
        wb(1'b0, ADDR_STATIC_CONFIG, 4'hF, 32'h0000_0000);
        `CHK("static", cfgw(0, 7, 4, 0, 0, 0) & 32'h00FF_FFFF, rdat)
        wb(1'b1, ADDR_STATIC_CONFIG, 4'hF, cfgw(0, 7, 4, 0, 0, 0));
        chv(1);
        `CHK("violations", exp_viol, viol_seen)
        wb(1'b0, ADDR_STATUS, 4'hF, 32'h0000_0000);
        `CHK("status", 32'h0000_0000, rdat)
        start(0, 7, 0, 0, 0, 0);
        r = $urandom;
        if (r == RESTART_VALUE) r = 32'h0000_0000;
        wb(1'b1, ADDR_COUNTER_RESTART, 4'hF, r);
        chv(1);
        `CHK("violations", exp_viol, viol_seen)
        for (int i = 0; i < 5; i++) begin
            start(0, 7, WA[i], WB[i], 0, 0);
            if (CH[i] == 1) begin
                wb(1'b1, ADDR_DYNAMIC_CONFIG, 4'hF, {KEY_DYNAMIC, 24'h00_0001});
                wb(1'b0, ADDR_DYNAMIC_CONFIG, 4'hF, 32'h0000_0000);
                `CHK("dynamic", 32'h0000_0001, rdat)
            end
            wait_c(TK[i] * LF);
            wb(1'b1, ADDR_COUNTER_RESTART, 4'hF, RESTART_VALUE);
            chv(EV[i]);
            `CHK("violations", exp_viol, viol_seen)
            if (EV[i] == 0) begin
                wait_c(56 * LF);
                chv(0);
                `CHK("violations", exp_viol, viol_seen)
                wait_c(16 * LF);
                chv(1);
                `CHK("violations", exp_viol, viol_seen)
            end
        end
        // Low-power freeze, debug halt, and low-power run-on
        for (int k = 0; k < 3; k++) begin
            start(0, 7, 0, 0, 0, int'(k == 0));
            if (k == 1) debug_halt <= 1'b1;
            else wb(1'b1, ADDR_LOW_POWER_CTRL, 4'hF, 32'h0000_0001);
            wait_c(100 * LF);
            chv(int'(k == 2));
            `CHK("violations", exp_viol, viol_seen)
            if (k == 0) wb(1'b1, ADDR_LOW_POWER_CTRL, 4'hF, 32'h0000_0000);
            if (k == 1) wb(1'b1, ADDR_DEBUG_CONTROL, 4'hF, 32'h0000_0001);
            if (k != 2) begin
                wait_c(66 * LF);
                chv(1);
                `CHK("violations", exp_viol, viol_seen)
            end
            debug_halt <= 1'b0;
        end
        for (int j = 0; j < 3; j++) begin
            start(DV[j], PR[j], 0, 0, 1, 0);
            n0 = irq_n;
            wait_c((2 * TT[j] + 8) * LF);
            `CHK("irq count", n0 + 2, irq_n)
            `CHK("irq gap", TT[j] * LF, gap)
            chv(0);
            `CHK("violations", exp_viol, viol_seen)
        end
        n0 = irq_n;
        wb(1'b1, ADDR_DYNAMIC_CONFIG, 4'hF, {8'h5A, 24'h00_0001});
        chv(0);
        `CHK("irq count", n0 + 1, irq_n)
        `CHK("violations", exp_viol, viol_seen)
        results();
    end
endmodule : wwd_window_watchdog_tb_top
